// ===== hw/fps_map.vh
// Register map, field positions and reset values of the flash protection
// and command status block. Included by the block's only design file.
//
// ****************************************************************
// How it works
// [RULE_01] Polarity one: enabled ranges protected, else none
// [RULE_02] Polarity zero, both disabled: whole array protected
// [RULE_03] Polarity zero: enabled ranges open, rest protected
// [RULE_04] High size picks 2K..16K window ending 0xFFFF
// [RULE_05] Low size picks 1K..8K window from 0x4000
// [RULE_06] Setting loaded from array; normal mode may change
// [RULE_07] Disallowed transition write ignored, register kept
// [RULE_08] Allowed scenario transitions per fixed table
// [RULE_09] Scenario index is polarity, high, low disable
// [RULE_10] Reading protection gives the scenario in force
// [RULE_11] Size field written only while its disable set
// [RULE_12] Normal mode status access; fail, done read zero
// [RULE_13] Special mode: fail writable, done readable
// [RULE_14] Buffer-empty flag bit 7, write one clears
// [RULE_15] Write zero mid-sequence aborts, sets access error
// [RULE_16] Buffer-empty with enable raises interrupt
// [RULE_17] Complete bit 6 clears with buffer-empty, sets at end
// [RULE_18] Complete flag not writable; with enable interrupts
// ****************************************************************
`ifndef FPS_MAP_VH
`define FPS_MAP_VH

// Word indices; byte address is four times the index
`define FPS_IDX_CONFIG      4'h3
`define FPS_IDX_PROTECT     4'h4
`define FPS_IDX_STATUS      4'h5
`define FPS_IDX_EVT_STATUS  4'h8
`define FPS_IDX_EVT_CLEAR   4'h9
`define FPS_IDX_EVT_ENABLE  4'hA

// Protection fields
`define FPS_PR_POL          7
`define FPS_PR_SPARE        6
`define FPS_PR_HDIS         5
`define FPS_PR_HS_HI        4
`define FPS_PR_HS_LO        3
`define FPS_PR_LDIS         2
`define FPS_PR_LS_HI        1
`define FPS_PR_LS_LO        0
`define FPS_PROT_RESET      8'hFF

// Status fields
`define FPS_ST_BUF_EMPTY    7
`define FPS_ST_COMPLETE     6
`define FPS_ST_VIOL         5
`define FPS_ST_ACC_ERR      4
`define FPS_ST_BLANK        2
`define FPS_ST_FAIL         1
`define FPS_ST_DONE         0

// Config fields
`define FPS_CF_BUF_IRQ_EN   7
`define FPS_CF_CMP_IRQ_EN   6

// Event interrupt fields
`define FPS_EV_VIOL         0
`define FPS_EV_ACC_ERR      1
`define FPS_EV_COMPLETE     2

// Allowed target scenarios, one mask per source scenario
`define FPS_ALLOW_0         8'h0F
`define FPS_ALLOW_1         8'h0A
`define FPS_ALLOW_2         8'h0C
`define FPS_ALLOW_3         8'h08
`define FPS_ALLOW_4         8'h18
`define FPS_ALLOW_5         8'h3C
`define FPS_ALLOW_6         8'h5A
`define FPS_ALLOW_7         8'hFF

// Window bounds
`define FPS_HI_BASE_2K      16'hF800
`define FPS_HI_BASE_4K      16'hF000
`define FPS_HI_BASE_8K      16'hE000
`define FPS_HI_BASE_16K     16'hC000
`define FPS_LO_BASE         16'h4000
`define FPS_LO_END_1K       16'h43FF
`define FPS_LO_END_2K       16'h47FF
`define FPS_LO_END_4K       16'h4FFF
`define FPS_LO_END_8K       16'h5FFF

`endif

// ===== hw/fps_top.v
// Flash protection window, protection register and command status flags.
// Assumes the command machine runs on ref_clk_i and gives one-cycle pulses;
// the special mode strap comes from a pin and is synchronised here.
`timescale 1ns/1ps
`include "fps_map.vh"

module fps_top (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // Avalon-MM slave
    input  wire [5:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Mode strap and nonvolatile load
    input  wire        special_mode_i,
    input  wire        nv_load_i,
    input  wire [7:0]  nv_prot_i,
    // Command machine side
    input  wire        flash_word_write_i,
    input  wire        buffer_free_i,
    input  wire        all_done_i,
    input  wire        violation_set_i,
    input  wire        access_error_set_i,
    input  wire        blank_set_i,
    input  wire        fail_set_i,
    input  wire        op_active_i,
    output reg         cmd_launch_o,
    output reg         seq_abort_o,
    // Protection check
    input  wire [15:0] flash_addr_i,
    output wire        addr_protected_o,
    output wire [7:0]  protection_config_o,
    output wire        irq_o
);

// ****************************************************************
// Declarations
// ****************************************************************
reg         ack;
reg         mode_meta;
reg         mode_sync;
reg         nv_done;
reg  [7:0]  protection_config;
reg         buffer_empty_flag;
reg         command_complete_flag;
reg         violation_flag;
reg         access_error_flag;
reg         blank_flag;
reg         fail_flag;
reg         seq_active;
reg         buffer_empty_irq_enable;
reg         complete_irq_enable;
reg  [2:0]  evt_status;
reg  [2:0]  evt_enable;

wire        req;
wire        wr_go;
wire [3:0]  idx;
wire [7:0]  wbyte;
wire [2:0]  scen_from;
wire [2:0]  scen_to;
reg  [7:0]  allow_mask;
wire        allowed;
reg  [15:0] hi_base;
reg  [15:0] lo_end;
wire        in_high;
wire        in_low;
wire        en_high;
wire        en_low;
wire        st_write;
wire        clr_buf_empty;
wire        abort_seq;
wire        launch;
wire [7:0]  status_view;
reg  [31:0] next_readdata;
reg  [7:0]  next_prot;

// ****************************************************************
// Bus slave
// ****************************************************************
// One wait cycle: the request is taken on the second edge it is held
assign req               = avs_read_i | avs_write_i;
assign avs_waitrequest_o = req & ~ack;
assign wr_go             = avs_write_i & ack;
assign idx               = avs_address_i[5:2];
assign wbyte             = avs_writedata_i[7:0];

always @(posedge ref_clk_i) begin
    if (rst_i) begin
        ack <= 1'b0;
    end else begin
        ack <= req & ~ack;
    end
end

// Read data captured in the wait cycle so it stands at the taking edge
always @* begin
    next_readdata = 32'h0000_0000;
    case (idx)
        `FPS_IDX_CONFIG: begin
            next_readdata[`FPS_CF_BUF_IRQ_EN] = buffer_empty_irq_enable;
            next_readdata[`FPS_CF_CMP_IRQ_EN] = complete_irq_enable;
        end
        `FPS_IDX_PROTECT: begin
            next_readdata[7:0] = protection_config; // [RULE_10]
        end
        `FPS_IDX_STATUS: begin
            next_readdata[7:0] = status_view;
        end
        `FPS_IDX_EVT_STATUS: begin
            next_readdata[2:0] = evt_status;
        end
        `FPS_IDX_EVT_ENABLE: begin
            next_readdata[2:0] = evt_enable;
        end
        default: begin
            next_readdata = 32'h0000_0000;
        end
    endcase
end

always @(posedge ref_clk_i) begin
    if (rst_i) begin
        avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack) begin
        avs_readdata_o <= next_readdata;
    end
end

// ****************************************************************
// Mode strap synchroniser
// ****************************************************************
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        mode_meta <= 1'b0;
        mode_sync <= 1'b0;
    end else begin
        mode_meta <= special_mode_i;
        mode_sync <= mode_meta;
    end
end

// ****************************************************************
// Protection register
// ****************************************************************
assign scen_from = {protection_config[`FPS_PR_POL],
                    protection_config[`FPS_PR_HDIS],
                    protection_config[`FPS_PR_LDIS]}; // [RULE_09]
assign scen_to   = {wbyte[`FPS_PR_POL], wbyte[`FPS_PR_HDIS], wbyte[`FPS_PR_LDIS]}; // [RULE_09]

always @* begin
    case (scen_from) // [RULE_08]
        3'h0:    allow_mask = `FPS_ALLOW_0;
        3'h1:    allow_mask = `FPS_ALLOW_1;
        3'h2:    allow_mask = `FPS_ALLOW_2;
        3'h3:    allow_mask = `FPS_ALLOW_3;
        3'h4:    allow_mask = `FPS_ALLOW_4;
        3'h5:    allow_mask = `FPS_ALLOW_5;
        3'h6:    allow_mask = `FPS_ALLOW_6;
        default: allow_mask = `FPS_ALLOW_7;
    endcase
end

assign allowed = allow_mask[scen_to]; // [RULE_08]

// Size fields keep old value unless their range was disabled before the write
always @* begin
    next_prot = protection_config;
    next_prot[`FPS_PR_POL]  = wbyte[`FPS_PR_POL];
    next_prot[`FPS_PR_HDIS] = wbyte[`FPS_PR_HDIS];
    next_prot[`FPS_PR_LDIS] = wbyte[`FPS_PR_LDIS];
    if (protection_config[`FPS_PR_HDIS]) begin
        next_prot[`FPS_PR_HS_HI:`FPS_PR_HS_LO] = wbyte[`FPS_PR_HS_HI:`FPS_PR_HS_LO]; // [RULE_11]
    end
    if (protection_config[`FPS_PR_LDIS]) begin
        next_prot[`FPS_PR_LS_HI:`FPS_PR_LS_LO] = wbyte[`FPS_PR_LS_HI:`FPS_PR_LS_LO]; // [RULE_11]
    end
end

// Reset value leaves the array open until the array copy arrives
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        protection_config <= `FPS_PROT_RESET;
        nv_done           <= 1'b0;
    end else if (nv_load_i & ~nv_done) begin
        protection_config <= nv_prot_i; // [RULE_06]
        nv_done           <= 1'b1;
    end else if (wr_go && idx == `FPS_IDX_PROTECT && !mode_sync && allowed) begin
        protection_config <= next_prot; // [RULE_06] [RULE_07]
    end
end

assign protection_config_o = protection_config;

// ****************************************************************
// Address windows
// ****************************************************************
always @* begin
    case (protection_config[`FPS_PR_HS_HI:`FPS_PR_HS_LO]) // [RULE_04]
        2'h0:    hi_base = `FPS_HI_BASE_2K;
        2'h1:    hi_base = `FPS_HI_BASE_4K;
        2'h2:    hi_base = `FPS_HI_BASE_8K;
        default: hi_base = `FPS_HI_BASE_16K;
    endcase
    case (protection_config[`FPS_PR_LS_HI:`FPS_PR_LS_LO]) // [RULE_05]
        2'h0:    lo_end = `FPS_LO_END_1K;
        2'h1:    lo_end = `FPS_LO_END_2K;
        2'h2:    lo_end = `FPS_LO_END_4K;
        default: lo_end = `FPS_LO_END_8K;
    endcase
end

assign in_high = flash_addr_i >= hi_base;                                  // [RULE_04]
assign in_low  = (flash_addr_i >= `FPS_LO_BASE) && (flash_addr_i <= lo_end); // [RULE_05]
assign en_high = ~protection_config[`FPS_PR_HDIS] & in_high;
assign en_low  = ~protection_config[`FPS_PR_LDIS] & in_low;

// Polarity zero with both ranges disabled falls out as all protected
assign addr_protected_o = protection_config[`FPS_PR_POL] ? (en_high | en_low) // [RULE_01]
                                                         : ~(en_high | en_low); // [RULE_02] [RULE_03]

// ****************************************************************
// Command status flags
// ****************************************************************
assign st_write  = wr_go && idx == `FPS_IDX_STATUS;
assign clr_buf_empty = st_write & wbyte[`FPS_ST_BUF_EMPTY] & buffer_empty_flag; // [RULE_14]
assign abort_seq     = st_write & ~wbyte[`FPS_ST_BUF_EMPTY] & seq_active;       // [RULE_15]
// A launch with an error flag still set is refused and flagged as access error;
// the buffer then stays empty, so the complete flag keeps following it
assign launch        = clr_buf_empty & ~violation_flag & ~access_error_flag & ~fail_flag;

assign status_view = {buffer_empty_flag, command_complete_flag, violation_flag,
                      access_error_flag, 1'b0, blank_flag,
                      fail_flag & mode_sync,                   // [RULE_12] [RULE_13]
                      ~op_active_i & mode_sync};               // [RULE_12] [RULE_13]

always @(posedge ref_clk_i) begin
    if (rst_i) begin
        buffer_empty_flag     <= 1'b1;
        command_complete_flag <= 1'b1;
        violation_flag        <= 1'b0;
        access_error_flag     <= 1'b0;
        blank_flag            <= 1'b0;
        fail_flag             <= 1'b0;
        seq_active            <= 1'b0;
        cmd_launch_o          <= 1'b0;
        seq_abort_o           <= 1'b0;
    end else begin
        cmd_launch_o <= launch;
        seq_abort_o  <= abort_seq;
        // Set wins over a clear in the same cycle, except seq_active where the clear wins
        if (buffer_free_i) begin
            buffer_empty_flag <= 1'b1;
        end else if (launch) begin
            buffer_empty_flag <= 1'b0; // [RULE_14]
        end
        if (all_done_i) begin
            command_complete_flag <= 1'b1; // [RULE_17]
        end else if (launch) begin
            command_complete_flag <= 1'b0; // [RULE_17] [RULE_18]
        end
        if (violation_set_i) begin
            violation_flag <= 1'b1;
        end else if (st_write & wbyte[`FPS_ST_VIOL]) begin
            violation_flag <= 1'b0; // [RULE_12]
        end
        if (access_error_set_i | abort_seq | (clr_buf_empty & ~launch)) begin
            access_error_flag <= 1'b1; // [RULE_15]
        end else if (st_write & wbyte[`FPS_ST_ACC_ERR]) begin
            access_error_flag <= 1'b0; // [RULE_12]
        end
        if (blank_set_i) begin
            blank_flag <= 1'b1;
        end else if (launch) begin
            blank_flag <= 1'b0;
        end
        if (fail_set_i & mode_sync) begin
            fail_flag <= 1'b1;
        end else if (st_write & wbyte[`FPS_ST_FAIL] & mode_sync) begin
            fail_flag <= 1'b0; // [RULE_13]
        end
        if (abort_seq | clr_buf_empty) begin
            seq_active <= 1'b0;
        end else if (flash_word_write_i & buffer_empty_flag) begin
            seq_active <= 1'b1; // [RULE_15]
        end
    end
end

// ****************************************************************
// Configuration and interrupts
// ****************************************************************
always @(posedge ref_clk_i) begin
    if (rst_i) begin
        buffer_empty_irq_enable <= 1'b0;
        complete_irq_enable     <= 1'b0;
        evt_enable              <= 3'h0;
        evt_status              <= 3'h0;
    end else begin
        if (wr_go && idx == `FPS_IDX_CONFIG) begin
            buffer_empty_irq_enable <= wbyte[`FPS_CF_BUF_IRQ_EN];
            complete_irq_enable     <= wbyte[`FPS_CF_CMP_IRQ_EN];
        end
        if (wr_go && idx == `FPS_IDX_EVT_ENABLE) begin
            evt_enable <= wbyte[2:0];
        end
        // Sticky events; a new event beats a clear in the same cycle
        evt_status <= (evt_status & ~((wr_go && idx == `FPS_IDX_EVT_CLEAR) ? wbyte[2:0] : 3'h0))
                    | {all_done_i, access_error_set_i | abort_seq, violation_set_i};
    end
end

assign irq_o = (buffer_empty_flag & buffer_empty_irq_enable)      // [RULE_16]
             | (command_complete_flag & complete_irq_enable)      // [RULE_18]
             | (|(evt_status & evt_enable));

endmodule // fps_top

// ===== bench/fps_top_sva.sv
// Port assertions for the flash protection and command status block.
// Assumes one clock, a synchronous active-high reset and one bus master.
`timescale 1ns/1ps
module fps_top_sva (
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire [5:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    input wire        nv_load_i,
    input wire [15:0] flash_addr_i,
    input wire        addr_protected_o,
    input wire [7:0]  protection_config_o,
    input wire        cmd_launch_o,
    input wire        seq_abort_o
);
    // ********
    // Helpers
    // ********
    localparam logic [63:0] ALLOW = 64'hFF5A3C18080C0A0F;
    wire       req = avs_read_i | avs_write_i;
    wire       stwr = avs_write_i && !avs_waitrequest_o && avs_address_i[5:2] == 4'h5;
    wire [2:0] sc = {protection_config_o[7], protection_config_o[5], protection_config_o[2]};

    // Windows computed arithmetically so a wrong table entry in the design shows
    function automatic logic fps_prot(input logic [7:0] c, input logic [15:0] a);
        logic hit;
        hit = (!c[5] && a >= (16'hFFFF << (5'd11 + c[4:3])))
            || (!c[2] && a >= 16'h4000 && a <= 16'h3FFF + (16'h0400 << c[1:0]));
        return c[7] ? hit : !hit;
    endfunction

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wait;
        req && avs_waitrequest_o;
    endsequence
    sequence s_taken;
        req && !avs_waitrequest_o;
    endsequence

    // ********
    // Checks
    // ********
    chk_wait_one_cycle: assert property ($rose(req) |-> s_wait ##1 s_taken)
        else $error("waitrequest not one cycle");
    chk_read_upper_zero: assert property (s_taken ##0 avs_read_i |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_read_prot_value: assert property (
        s_taken ##0 (avs_read_i && avs_address_i[5:2] == 4'h4)
        |-> avs_readdata_o[7:0] == protection_config_o) else $error("protection read differs");
    chk_prot_window: assert property (
        addr_protected_o == fps_prot(protection_config_o, flash_addr_i))
        else $error("protection decode wrong");
    chk_trans_legal: assert property (
        $changed(protection_config_o) && !$past(nv_load_i) && !$past(rst_i)
        |-> ALLOW[{$past(sc), sc}]) else $error("illegal protection transition");
    chk_size_lock: assert property (
        !$past(nv_load_i) && !$past(rst_i)
        |-> ($past(protection_config_o[5]) || $stable(protection_config_o[4:3]))
         && ($past(protection_config_o[2]) || $stable(protection_config_o[1:0])))
        else $error("size changed while range enabled");
    chk_launch_cause: assert property (cmd_launch_o |-> $past(stwr) && $past(avs_writedata_i[7]))
        else $error("launch without status write");
    chk_abort_cause: assert property (seq_abort_o |-> $past(stwr) && !$past(avs_writedata_i[7]))
        else $error("abort without zero write");
    chk_launch_pulse: assert property (cmd_launch_o |=> !cmd_launch_o && !seq_abort_o)
        else $error("launch pulse too long");
endmodule // fps_top_sva

// ===== bench/tb_fps_top.sv
// Self-checking bench for the flash protection and command status block.
// Assumes the block alone; the bench plays bus master and command machine.
`timescale 1ns/1ps
module tb_fps_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [5:0]  avs_address_i;
    logic        avs_read_i, avs_write_i, special_mode_i, op_active_i;
    logic [31:0] avs_writedata_i;
    logic [7:0]  nv_prot_i, q;
    logic [7:0]  evt;
    logic [15:0] flash_addr_i;
    wire  [31:0] avs_readdata_o;
    wire  [7:0]  protection_config_o;
    wire         avs_waitrequest_o, cmd_launch_o, seq_abort_o, addr_protected_o, irq_o;
    int          n_errors, checks, cyc;
    // Allowed target scenarios, one row per source scenario
    logic [7:0]  allow [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};

    fps_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .special_mode_i(special_mode_i), .nv_load_i(evt[0]), .nv_prot_i(nv_prot_i),
        .flash_word_write_i(evt[1]), .buffer_free_i(evt[2]), .all_done_i(evt[3]),
        .violation_set_i(evt[4]), .access_error_set_i(evt[7]), .blank_set_i(evt[6]),
        .fail_set_i(evt[5]), .op_active_i(op_active_i), .cmd_launch_o(cmd_launch_o),
        .seq_abort_o(seq_abort_o), .flash_addr_i(flash_addr_i),
        .addr_protected_o(addr_protected_o), .protection_config_o(protection_config_o),
        .irq_o(irq_o));

    always #12.5 ref_clk_i = ~ref_clk_i;

    // ********
    // Tasks
    // ********
    task automatic conclude();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Hang guard well above the roughly 1000 cycles the sequence needs
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask

    task automatic pulse(input int k);
        @(posedge ref_clk_i);
        evt <= 8'h01 << k;
        @(posedge ref_clk_i);
        evt <= 8'h00;
        #1;
    endtask

    task automatic pa(input logic [15:0] a, input logic e);
        @(posedge ref_clk_i);
        flash_addr_i <= a;
        #1;
        chk("protected", e, addr_protected_o);
    endtask

    task automatic do_reset();
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
    endtask

    function automatic logic [7:0] sv(input logic [2:0] s);
        return {s[2], 1'b1, s[1], 2'b00, s[0], 2'b00};
    endfunction

    // ********
    // Sequence
    // ********
    initial begin
        {avs_address_i, avs_read_i, avs_write_i, special_mode_i, op_active_i} = '0;
        {avs_writedata_i, nv_prot_i, evt, flash_addr_i} = '0;
        do_reset();
        rd(6'h10, 8'hFF, "prot reset");
        rd(6'h14, 8'hC0, "status reset");
        for (int f = 0; f < 8; f++) for (int t = 0; t < 8; t++) begin
            do_reset();
            wr(6'h10, sv(f[2:0]));
            wr(6'h10, sv(t[2:0]));
            rd(6'h10, allow[f][t] ? sv(t[2:0]) : sv(f[2:0]), "scenario");
        end
        do_reset();
        wr(6'h10, 8'hE5);
        wr(6'h10, 8'hC1);
        rd(6'h10, 8'hC1, "prot");
        pa(16'hF800, 1'b1);
        pa(16'hF7FF, 1'b0);
        pa(16'h47FF, 1'b1);
        pa(16'h4800, 1'b0);
        wr(6'h10, 8'h3F);
        rd(6'h10, 8'h65, "prot");
        pa(16'h8000, 1'b1);
        do_reset();
        wr(6'h10, 8'h08);
        pa(16'hF000, 1'b0);
        pa(16'hEFFF, 1'b1);
        pa(16'h43FF, 1'b0);
        pa(16'h4400, 1'b1);
        do_reset();
        nv_prot_i <= 8'h91;
        pulse(0);
        rd(6'h10, 8'h91, "nv load");
        nv_prot_i <= 8'hFF;
        pulse(0);
        rd(6'h10, 8'h91, "nv second");
        do_reset();
        wr(6'h0C, 8'h80);
        chk("irq", 1'b1, irq_o);
        pulse(6);
        wr(6'h14, 8'h44);
        rd(6'h14, 8'hC4, "status");
        wr(6'h14, 8'h80);
        chk("launch", 1'b1, cmd_launch_o);
        rd(6'h14, 8'h00, "status");
        chk("irq", 1'b0, irq_o);
        pulse(2);
        rd(6'h14, 8'h80, "status");
        pulse(3);
        rd(6'h14, 8'hC0, "status");
        wr(6'h0C, 8'h40);
        chk("irq", 1'b1, irq_o);
        wr(6'h0C, 8'h00);
        chk("irq", 1'b0, irq_o);
        pulse(1);
        wr(6'h14, 8'h00);
        chk("abort", 1'b1, seq_abort_o);
        rd(6'h14, 8'hD0, "status");
        wr(6'h14, 8'h10);
        wr(6'h14, 8'h00);
        rd(6'h14, 8'hC0, "status");
        pulse(4);
        pulse(5);
        pulse(7);
        rd(6'h14, 8'hF0, "status");
        wr(6'h14, 8'h80);
        chk("launch", 1'b0, cmd_launch_o);
        rd(6'h14, 8'hF0, "refused");
        wr(6'h14, 8'h30);
        rd(6'h14, 8'hC0, "status");
        rd(6'h20, 8'h07, "events");
        wr(6'h28, 8'h01);
        rd(6'h28, 8'h01, "enable");
        chk("irq", 1'b1, irq_o);
        wr(6'h24, 8'h01);
        chk("irq", 1'b0, irq_o);
        rd(6'h20, 8'h06, "events");
        rd(6'h3C, 8'h00, "unmapped");
        @(posedge ref_clk_i);
        special_mode_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        pulse(5);
        rd(6'h14, 8'hC3, "special");
        wr(6'h14, 8'h02);
        rd(6'h14, 8'hC1, "special");
        op_active_i <= 1'b1;
        rd(6'h14, 8'hC0, "done");
        wr(6'h10, 8'h24);
        rd(6'h10, 8'hFF, "prot special");
        conclude();
    end
endmodule // tb_fps_top

bind fps_top fps_top_sva u_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .nv_load_i(nv_load_i), .flash_addr_i(flash_addr_i),
    .addr_protected_o(addr_protected_o), .protection_config_o(protection_config_o),
    .cmd_launch_o(cmd_launch_o), .seq_abort_o(seq_abort_o));
